/* File: verilog/tcu_consts.svh */
// Offsets, field positions, reset values and widths for the timer capture/edge unit.
`ifndef TCU_CONSTS_SVH
`define TCU_CONSTS_SVH
`define TCU_OFS_CTRL     8'h00
`define TCU_OFS_EDGE     8'h04
`define TCU_OFS_PRM      8'h08
`define TCU_OFS_COUNT    8'h0C
`define TCU_OFS_CC_A     8'h10
`define TCU_OFS_CC_B     8'h14
`define TCU_OFS_STATUS   8'h18
`define TCU_OFS_MASK     8'h1C
`define TCU_CTRL_RUN     0
`define TCU_CTRL_MODE_LO 1
`define TCU_CTRL_MODE_HI 2
`define TCU_CTRL_CAP_A   3
`define TCU_CTRL_CAP_B   4
`define TCU_CTRL_FIRE    6
`define TCU_ST_WRAP      2
`define TCU_CTRL_RST     5'h0_0
`define TCU_EDGE_RST     4'h0
`define TCU_PRM_RST      2'h0
`define TCU_CNT_MAX      16'hFFFF
`define TCU_SYNC_STAGES  2
`endif

/* File: verilog/tcu_pkg.sv */
// Types shared by the timer capture/edge unit.
package tcu_pkg;
  typedef enum logic [1:0] {
    MODE_FREE      = 2'h0,
    MODE_CLR_EDGE  = 2'h1,
    MODE_CLR_MATCH = 2'h3
  } count_mode_e;
  typedef enum logic [1:0] {
    PRM_DIV2 = 2'h0,
    PRM_DIV4 = 2'h1,
    PRM_DIV8 = 2'h2,
    PRM_EXT  = 2'h3
  } prescaler_e;
endpackage : tcu_pkg

/* File: verilog/edge_filter.sv */
// Two-sample noise filter and valid-edge detector for one trigger pin.
`timescale 1ns/1ps
module edge_filter (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic       sample_en,
  input  wire logic       pin_sync,
  input  wire logic [1:0] edge_sel,
  output logic            edge_pulse
);
  logic smp_ff;
  logic level_ff;
  logic armed_ff;
  logic edge_ff;
  logic agree;

  // An edge counts only when two successive samples agree and differ from the stored level.
  assign agree = run && sample_en && (pin_sync == smp_ff) && (pin_sync != level_ff);

  // =====================================================
  // Sample and level store
  // Reset forces the level low, so a pin already high reads as a rising edge on first start.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      smp_ff   <= 1'b0;
      level_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else if (ce) begin
      if (run) begin
        armed_ff <= 1'b1;
        if (sample_en) smp_ff <= pin_sync;
        if (agree) level_ff <= pin_sync;
      end else if (armed_ff) begin
        // Once started, a stop tracks the pin quietly so a restart sees no stale edge.
        smp_ff   <= pin_sync;
        level_ff <= pin_sync;
      end
    end
  end

  // Qualify the direction: bit 1 selects rising, bit 0 falling.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) edge_ff <= 1'b0;
    else if (ce) edge_ff <= agree && (pin_sync ? edge_sel[1] : edge_sel[0]);
  end
  // The pulse is gated by run, so a stop in the cycle of an edge cannot leak that edge.
  assign edge_pulse = edge_ff && run;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn || !ce);

  a_two_sample_edge: assert property (edge_ff |-> $past(smp_ff) == level_ff)
    else $error("Edge reported without two agreeing samples.");
  a_restart_quiet: assert property (armed_ff && !run |=> level_ff == $past(pin_sync))
    else $error("Stopped filter did not track the pin.");
endmodule : edge_filter

/* File: verilog/timer_capture_edge_unit.sv */
// Capture/compare, count clock and trigger edge logic of a 16-bit timer with an AHB-Lite register port.
// =====================================================
`timescale 1ns/1ps
`include "tcu_consts.svh"
module timer_capture_edge_unit #(
  parameter int CNT_W = 16
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        first_trigger_pin,
  input  wire logic        second_trigger_pin,
  output logic             irq,
  output logic             oneshot_out
);
  logic [7:0]       ap_addr_ff;
  logic             ap_wr_ff;
  logic             ap_valid_ff;
  logic [31:0]      hrdata_ff;
  logic [4:0]       ctrl_ff;
  logic [3:0]       edge_cfg_ff;
  logic [1:0]       prm_ff;
  logic [2:0]       status_ff;
  logic [2:0]       mask_ff;
  logic             irq_ff;
  logic             oneshot_ff;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] cc_ff [2];
  logic [3:0]       div_ff;
  logic             ext_fall_ff;
  logic [1:0]       sync1_ff;
  logic [1:0]       sync2_ff;
  logic [1:0]       trig;
  logic [1:0]       sample_en;
  logic [1:0]       cap_mode;
  logic [1:0]       cap_now;
  logic [1:0]       evt_set;
  logic [1:0]       wr_cc;
  logic             run;
  logic             ext_clk;
  logic             cnt_rise;
  logic             cnt_fall;
  logic             wrap_set;
  logic             wr_en;
  logic             rd_take;
  logic             clr_pend_ff;
  logic             edge_clr;
  logic             fire_wr;
  logic [3:0]       div_last;
  logic [3:0]       div_half;
  tcu_pkg::count_mode_e mode;

  assign run      = ctrl_ff[`TCU_CTRL_RUN];
  assign mode     = tcu_pkg::count_mode_e'(ctrl_ff[`TCU_CTRL_MODE_HI:`TCU_CTRL_MODE_LO]);
  assign cap_mode = {ctrl_ff[`TCU_CTRL_CAP_B], ctrl_ff[`TCU_CTRL_CAP_A]};
  assign ext_clk  = (prm_ff == tcu_pkg::PRM_EXT);

  // =====================================================
  // Bus slave: zero wait states, always OKAY
  // Read data is fetched in the address phase so hrdata leaves a flip-flop.
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  assign wr_en   = ap_valid_ff && ap_wr_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ap_addr_ff  <= 8'h00;
      ap_wr_ff    <= 1'b0;
      ap_valid_ff <= 1'b0;
    end else if (ce && hready) begin
      ap_addr_ff  <= haddr[7:0];
      ap_wr_ff    <= hwrite;
      ap_valid_ff <= hsel && htrans[1];
    end
  end

  // Unmapped offsets read as zero. A counter read has no side effect on register B.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) hrdata_ff <= 32'h0000_0000;
    else if (ce && rd_take) begin
      case (haddr[7:0])
        `TCU_OFS_CTRL:   hrdata_ff <= {27'h000_0000, ctrl_ff};
        `TCU_OFS_EDGE:   hrdata_ff <= {28'h000_0000, edge_cfg_ff};
        `TCU_OFS_PRM:    hrdata_ff <= {30'h0000_0000, prm_ff};
        `TCU_OFS_COUNT:  hrdata_ff <= 32'(count_ff);
        `TCU_OFS_CC_A:   hrdata_ff <= 32'(cc_ff[0]);
        `TCU_OFS_CC_B:   hrdata_ff <= 32'(cc_ff[1]);
        `TCU_OFS_STATUS: hrdata_ff <= {29'h0000_0000, status_ff};
        `TCU_OFS_MASK:   hrdata_ff <= {29'h0000_0000, mask_ff};
        default:         hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Configuration registers written in the data phase.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff     <= `TCU_CTRL_RST;
      edge_cfg_ff <= `TCU_EDGE_RST;
      prm_ff      <= `TCU_PRM_RST;
      mask_ff     <= 3'h0;
    end else if (ce && wr_en) begin
      case (ap_addr_ff)
        `TCU_OFS_CTRL: ctrl_ff     <= hwdata[4:0];
        `TCU_OFS_EDGE: edge_cfg_ff <= hwdata[3:0];
        `TCU_OFS_PRM:  prm_ff      <= hwdata[1:0];
        `TCU_OFS_MASK: mask_ff     <= hwdata[2:0];
        default: ;
      endcase
    end
  end

  // =====================================================
  // Pin synchronisers
  // Pins are asynchronous; only the second stage feeds the filters.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
    end else if (ce) begin
      sync1_ff <= {second_trigger_pin, first_trigger_pin};
      sync2_ff <= sync1_ff;
    end
  end

  // =====================================================
  // Count clock
  // The internal count clock is high for the first half of each divided period.
  assign div_last = 4'((4'h2 << prm_ff) - 4'h1);
  assign div_half = 4'(4'h1 << prm_ff);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) div_ff <= 4'h0;
    else if (ce) div_ff <= (!run || div_ff == div_last) ? 4'h0 : 4'(div_ff + 4'h1);
  end

  // An external count clock has no width of its own, so its fall follows its rise by one cycle.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) ext_fall_ff <= 1'b0;
    else if (ce) ext_fall_ff <= ext_clk && trig[0];
  end

  assign cnt_rise = ext_clk ? trig[0] : (run && div_ff == 4'h0);
  assign cnt_fall = ext_clk ? ext_fall_ff : (run && div_ff == div_half);

  // The first pin samples every system clock as a count source, else on count clock rises.
  assign sample_en[0] = ext_clk ? 1'b1 : (run && div_ff == 4'h0);
  assign sample_en[1] = cnt_rise;

  // =====================================================
  // Per-pin filter and per-register capture/compare
  // Register A triggers from the first pin, register B from the second.
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic pend_ff;
    logic done_ff;
    logic cap_ok;
    logic match;

    edge_filter u_filt (
      .clk_sys    (clk_sys),
      .rstn       (rstn),
      .ce         (ce),
      .run        (run),
      .sample_en  (sample_en[i]),
      .pin_sync   (sync2_ff[i]),
      .edge_sel   (edge_cfg_ff[2*i+1:2*i]),
      .edge_pulse (trig[i])
    );

    // Captures only in capture mode, and never into A while its pin clocks the counter.
    assign cap_ok     = run && cap_mode[i] && !(i == 0 && ext_clk);
    assign cap_now[i] = cap_ok && cnt_fall && (pend_ff || trig[i]);
    assign match      = run && !cap_mode[i] && cnt_rise && count_ff == cc_ff[i];
    assign wr_cc[i]   = wr_en && ap_addr_ff == (i == 0 ? `TCU_OFS_CC_A : `TCU_OFS_CC_B);
    assign evt_set[i] = (done_ff && cnt_rise) || match;

    // A trigger waits here for the next falling edge of the count clock.
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) pend_ff <= 1'b0;
      else if (ce) begin
        if (!cap_ok || cap_now[i]) pend_ff <= 1'b0;
        else if (trig[i]) pend_ff <= 1'b1;
      end
    end

    // The interrupt waits for the following rise of the count clock.
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) done_ff <= 1'b0;
      else if (ce) begin
        if (cap_now[i]) done_ff <= 1'b1;
        else if (cnt_rise) done_ff <= 1'b0;
      end
    end

    // Capture overrides a software write in the same cycle.
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) cc_ff[i] <= '0;
      else if (ce) begin
        if (cap_now[i]) cc_ff[i] <= count_ff;
        else if (wr_cc[i]) cc_ff[i] <= hwdata[CNT_W-1:0];
      end
    end
  end

  // =====================================================
  // Clear on a first-pin edge
  // The clearing edge lands between count clock rises, so it is held here until the next rise.
  // A held request is dropped on a stop, so a restart never clears on an old edge.
  assign edge_clr = (mode == tcu_pkg::MODE_CLR_EDGE) && !ext_clk && (clr_pend_ff || trig[0]);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) clr_pend_ff <= 1'b0;
    else if (ce) begin
      if (!run || cnt_rise) clr_pend_ff <= 1'b0;
      else if (trig[0]) clr_pend_ff <= 1'b1;
    end
  end

  // =====================================================
  // Up-counter
  // Wrap is flagged both by overflow and by a match-clear at all ones.
  always_comb begin
    wrap_set = 1'b0;
    if (run && cnt_rise) begin
      if (mode == tcu_pkg::MODE_CLR_MATCH && count_ff == cc_ff[0])
        wrap_set = (cc_ff[0] == CNT_W'(`TCU_CNT_MAX));
      else if (!edge_clr)
        wrap_set = (count_ff == CNT_W'(`TCU_CNT_MAX));
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) count_ff <= '0;
    else if (ce && run && cnt_rise) begin
      if (mode == tcu_pkg::MODE_CLR_MATCH && count_ff == cc_ff[0])
        count_ff <= '0;
      else if (edge_clr)
        count_ff <= '0;
      else
        count_ff <= CNT_W'(count_ff + 1'b1);
    end
  end

  // =====================================================
  // One-shot output
  // Match-clear wraps only if register A is all ones or the count is above it, so the pulse could hang; it is blocked there.
  // A fire counts in the mode already running, so software must set the mode before it fires.
  assign fire_wr = wr_en && ap_addr_ff == `TCU_OFS_CTRL && hwdata[`TCU_CTRL_FIRE];
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) oneshot_ff <= 1'b0;
    else if (ce) begin
      if (mode == tcu_pkg::MODE_CLR_MATCH || !run) oneshot_ff <= 1'b0;
      else if (wrap_set) oneshot_ff <= 1'b0;
      else if (fire_wr) oneshot_ff <= 1'b1;
    end
  end
  assign oneshot_out = oneshot_ff;

  // =====================================================
  // Interrupt status, write one to clear
  // A set in the same cycle as its clear wins, so no event is lost.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) status_ff <= 3'h0;
    else if (ce) begin
      status_ff <= (status_ff & ~((wr_en && ap_addr_ff == `TCU_OFS_STATUS) ? hwdata[2:0] : 3'h0))
                 | {wrap_set, evt_set};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) irq_ff <= 1'b0;
    else if (ce) irq_ff <= |(status_ff & mask_ff);
  end
  assign irq = irq_ff;

  // =====================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn || !ce);

  sequence s_capture_a;
    cap_now[0] ##1 !cap_now[0];
  endsequence

  sequence s_fall_then_rise;
    cap_now[0] ##1 cnt_rise;
  endsequence

  a_stop_ignores_pins: assert property (!run |-> trig == 2'h0)
    else $error("Trigger edge seen while stopped.");
  a_oneshot_mode_block: assert property (mode == tcu_pkg::MODE_CLR_MATCH |=> !oneshot_ff)
    else $error("One-shot active in match-clear mode.");
  a_ext_no_capture: assert property (ext_clk |-> !cap_now[0])
    else $error("Capture into A while its pin clocks the counter.");
  a_capture_on_fall: assert property (cap_now[0] |-> cnt_fall ##1 cc_ff[0] == $past(count_ff))
    else $error("Capture A missed the count value at the fall.");
  a_irq_next_rise: assert property (s_capture_a ##0 (!cnt_rise)[*1] ##1 cnt_rise |=> status_ff[0])
    else $error("Capture interrupt not set at next rise.");
  a_compare_no_load: assert property (!cap_mode[1] |-> !cap_now[1])
    else $error("Compare-mode register loaded by a trigger.");
  a_ext_sample_rate: assert property (ext_clk |-> sample_en[0])
    else $error("External count pin not sampled every cycle.");
  a_int_sample_rate: assert property (!ext_clk && sample_en[0] |-> div_ff == 4'h0)
    else $error("Trigger pin sampled off the count clock.");
  a_wrap_beats_clear: assert property (wrap_set |=> status_ff[`TCU_ST_WRAP])
    else $error("Wrap flag lost against a clear.");
  a_count_read_quiet: assert property (rd_take && !cap_now[1] && !wr_cc[1] |=> $stable(cc_ff[1]))
    else $error("Counter read disturbed register B.");
  a_irq_fast_rise: assert property (s_fall_then_rise |=> status_ff[0])
    else $error("Capture interrupt not set at the rise right after the fall.");
  a_irq_level: assert property (|(status_ff & mask_ff) |=> irq_ff)
    else $error("Interrupt low while an unmasked status bit is set.");
  a_capture_wins_write: assert property (cap_now[1] && wr_cc[1] |=> cc_ff[1] == $past(count_ff))
    else $error("Software write beat a capture into register B.");
  a_oneshot_fire: assert property (fire_wr && run && mode != tcu_pkg::MODE_CLR_MATCH && !wrap_set |=> oneshot_ff)
    else $error("One-shot not started in an allowed mode.");
  a_edge_restart: assert property (run && cnt_rise && edge_clr |=> count_ff == '0)
    else $error("Counter not restarted by a clearing edge.");
endmodule : timer_capture_edge_unit

/* File: tb/tcu_pulse_src.sv */
// Model of the outside pulse sources that drive the two trigger pins.
`timescale 1ns/1ps
module tcu_pulse_src (
  input  wire logic clk_sys,
  output logic      first_trigger_pin,
  output logic      second_trigger_pin
);
  // =====================================================
  // Pin drivers
  // Both pins are driven at all times, so a level never floats between pulses.
  task automatic hold(input logic sel, input logic lvl);
    if (sel) second_trigger_pin <= lvl;
    else first_trigger_pin <= lvl;
  endtask : hold
  // A pulse is held for len cycles; capture pulses use well over two count clocks.
  task automatic pulse(input logic sel, input int len);
    @(posedge clk_sys);
    hold(sel, 1'b1);
    repeat (len) @(posedge clk_sys);
    hold(sel, 1'b0);
  endtask : pulse
endmodule : tcu_pulse_src

/* File: tb/timer_capture_edge_unit_tb_top.sv */
// Self-checking bench for the timer capture/edge unit over its register port.
`timescale 1ns/1ps
`include "tcu_consts.svh"
module timer_capture_edge_unit_tb_top;
  logic        clk_sys;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        ce;
  logic        pin_a;
  logic        pin_b;
  logic        irq;
  logic        oneshot_out;
  logic [31:0] rd;
  logic [31:0] cnt;
  int          n_mismatch;
  int          n_checks;

  // =====================================================
  // Design, pulse sources and clock
  // The clock enable is driven, so that a freeze can be shown to hold the count.
  timer_capture_edge_unit u_timer_capture_edge_unit (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .first_trigger_pin(pin_a),
    .second_trigger_pin(pin_b), .irq(irq), .oneshot_out(oneshot_out));
  tcu_pulse_src u_tcu_pulse_src (.clk_sys(clk_sys), .first_trigger_pin(pin_a), .second_trigger_pin(pin_b));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // =====================================================
  // Checking and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      close_out();
    end
  endtask : wait_ready

  // =====================================================
  // AHB-Lite single word transfers
  // Read data is taken at the edge that ends the data phase, before that edge's updates land.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_ready();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    check(name, rd, exp);
  endtask : rd_chk
  // Polls a status bit until it sets; running out of polls counts as a mismatch.
  task automatic wait_status(input int b);
    int n;
    n = 0;
    do begin
      xfer(`TCU_OFS_STATUS, 1'b0, 32'h0000_0000);
      n++;
    end while (rd[b] !== 1'b1 && n < 100);
    check("status_set", {31'h0000_0000, rd[b]}, 32'h0000_0001);
  endtask : wait_status

  // =====================================================
  // Main sequence
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    rstn = 1'b0;
    ce = 1'b1;
    {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    u_tcu_pulse_src.hold(1'b0, 1'b1);
    u_tcu_pulse_src.hold(1'b1, 1'b0);
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd_chk("ctrl_rst", `TCU_OFS_CTRL, 32'h0000_0000);
    rd_chk("status_rst", `TCU_OFS_STATUS, 32'h0000_0000);
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
    check("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
    // Stopped timer: a pulse on the second pin must leave no trace.
    wr(`TCU_OFS_EDGE, 32'h0000_000A);
    wr(`TCU_OFS_MASK, 32'h0000_0003);
    wr(`TCU_OFS_CTRL, 32'h0000_0018);
    u_tcu_pulse_src.pulse(1'b1, 20);
    repeat (10) @(posedge clk_sys);
    rd_chk("stopped", `TCU_OFS_STATUS, 32'h0000_0000);
    // First start with the first pin high since reset gives a rising edge.
    wr(`TCU_OFS_CTRL, 32'h0000_0019);
    wait_status(0);
    repeat (3) @(posedge clk_sys);
    check("irq_on", {31'h0000_0000, irq}, 32'h0000_0001);
    wr(`TCU_OFS_STATUS, 32'h0000_0003);
    repeat (3) @(posedge clk_sys);
    check("irq_off", {31'h0000_0000, irq}, 32'h0000_0000);
    // Restart with the pin high after a stop: no edge this time.
    wr(`TCU_OFS_CTRL, 32'h0000_0018);
    u_tcu_pulse_src.hold(1'b0, 1'b0);
    repeat (10) @(posedge clk_sys);
    u_tcu_pulse_src.hold(1'b0, 1'b1);
    repeat (10) @(posedge clk_sys);
    wr(`TCU_OFS_CTRL, 32'h0000_0019);
    repeat (20) @(posedge clk_sys);
    rd_chk("restart", `TCU_OFS_STATUS, 32'h0000_0000);
    // Divide by eight: a one-cycle glitch is rejected, a long pulse captures.
    wr(`TCU_OFS_PRM, {30'h0000_0000, tcu_pkg::PRM_DIV8});
    u_tcu_pulse_src.hold(1'b0, 1'b0);
    repeat (40) @(posedge clk_sys);
    u_tcu_pulse_src.pulse(1'b0, 1);
    repeat (40) @(posedge clk_sys);
    rd_chk("glitch", `TCU_OFS_STATUS, 32'h0000_0000);
    u_tcu_pulse_src.pulse(1'b0, 40);
    wait_status(0);
    xfer(`TCU_OFS_CC_A, 1'b0, 32'h0000_0000);
    cnt = rd;
    xfer(`TCU_OFS_COUNT, 1'b0, 32'h0000_0000);
    check("cap_value", {31'h0000_0000, (cnt != 0) && (cnt <= rd)}, 32'h0000_0001);
    // Counter reads must not load register B.
    wr(`TCU_OFS_STATUS, 32'h0000_0007);
    wr(`TCU_OFS_CC_B, 32'h0000_1234);
    repeat (4) xfer(`TCU_OFS_COUNT, 1'b0, 32'h0000_0000);
    rd_chk("cnt_read", `TCU_OFS_CC_B, 32'h0000_1234);
    // Register B in compare mode ignores its trigger.
    wr(`TCU_OFS_CTRL, 32'h0000_0009);
    u_tcu_pulse_src.pulse(1'b1, 40);
    repeat (10) @(posedge clk_sys);
    rd_chk("cmp_mode", `TCU_OFS_CC_B, 32'h0000_1234);
    // First pin as count clock: it counts each rising edge and never captures into A.
    wr(`TCU_OFS_CTRL, 32'h0000_0008);
    wr(`TCU_OFS_PRM, {30'h0000_0000, tcu_pkg::PRM_EXT});
    wr(`TCU_OFS_CC_A, 32'h0000_5555);
    wr(`TCU_OFS_EDGE, 32'h0000_0002);
    wr(`TCU_OFS_CTRL, 32'h0000_0009);
    repeat (10) @(posedge clk_sys);
    xfer(`TCU_OFS_COUNT, 1'b0, 32'h0000_0000);
    cnt = rd;
    repeat (3) begin
      u_tcu_pulse_src.pulse(1'b0, 4);
      repeat (4) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
    xfer(`TCU_OFS_COUNT, 1'b0, 32'h0000_0000);
    check("ext_count", rd - cnt, 32'h0000_0003);
    rd_chk("no_cap_a", `TCU_OFS_CC_A, 32'h0000_5555);
    // A pulse that falls wholly inside a clock-enable freeze is never counted.
    xfer(`TCU_OFS_COUNT, 1'b0, 32'h0000_0000);
    cnt = rd;
    ce <= 1'b0;
    u_tcu_pulse_src.pulse(1'b0, 4);
    repeat (4) @(posedge clk_sys);
    ce <= 1'b1;
    repeat (6) @(posedge clk_sys);
    xfer(`TCU_OFS_COUNT, 1'b0, 32'h0000_0000);
    check("freeze", rd, cnt);
    // One-shot: refused in clear-on-match mode, produced in clear-on-edge and free-running modes.
    // Each fire is written only once its mode is already running.
    wr(`TCU_OFS_PRM, {30'h0000_0000, tcu_pkg::PRM_DIV2});
    wr(`TCU_OFS_CTRL, 32'h0000_0007);
    wr(`TCU_OFS_CTRL, 32'h0000_0047);
    repeat (10) @(posedge clk_sys);
    check("os_match", {31'h0000_0000, oneshot_out}, 32'h0000_0000);
    wr(`TCU_OFS_CTRL, 32'h0000_0003);
    wr(`TCU_OFS_CTRL, 32'h0000_0043);
    for (int i = 0; i < 20 && oneshot_out !== 1'b1; i++) @(posedge clk_sys);
    check("os_edge", {31'h0000_0000, oneshot_out}, 32'h0000_0001);
    // In clear-on-edge mode a rising edge on the first pin restarts the count from zero.
    repeat (40) @(posedge clk_sys);
    u_tcu_pulse_src.pulse(1'b0, 12);
    xfer(`TCU_OFS_COUNT, 1'b0, 32'h0000_0000);
    check("edge_clear", {31'h0000_0000, rd < 32'h0000_0008}, 32'h0000_0001);
    wr(`TCU_OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    check("os_stop", {31'h0000_0000, oneshot_out}, 32'h0000_0000);
    wr(`TCU_OFS_CTRL, 32'h0000_0001);
    wr(`TCU_OFS_CTRL, 32'h0000_0041);
    for (int i = 0; i < 20 && oneshot_out !== 1'b1; i++) @(posedge clk_sys);
    check("os_free", {31'h0000_0000, oneshot_out}, 32'h0000_0001);
    close_out();
  end
endmodule : timer_capture_edge_unit_tb_top
